// File: hdl/rtc_serial_pkg.sv
// Behaviour
// RULE_01: transfers happen only while both chip-enable inputs are high together.
// RULE_02: after enable rises: 4-bit mode, 4-bit address, then whole bytes.
// RULE_03: mode, address and data bits travel least significant bit first.
// RULE_04: address steps by one after each byte, wrapping from F to 0.
// RULE_05: mode code 3 selects write; next four bits give start address.
// RULE_06: write mode stores each received byte at successive addresses; the code drops a byte that finds the update queue full and sets write_drop_o.
// RULE_07: a byte left unfinished when enable falls is not committed.
// RULE_08: mode code C selects read; next four bits give start address.
// RULE_09: read mode drives bytes from successive addresses while host clocks.
// RULE_10: any other mode code: ignore the rest, never drive data line.
// RULE_11: bits sampled on rising serial clock, read bits change on falling.
// RULE_12: enable fall releases data line and discards all partial state.
package rtc_serial_pkg;

    localparam int ADDR_W = 4;
    localparam int BYTE_W = 8;
    localparam int UPD_FIFO_DEPTH = 16;

    localparam logic [3:0] MODE_WRITE = 4'h3;
    localparam logic [3:0] MODE_READ = 4'hc;

    // bit counter values that close the mode nibble and a full byte
    localparam logic [2:0] MODE_LAST_BIT = 3'h3;
    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

    // positions inside the synchroniser vector
    localparam int SYNC_SCLK = 0;
    localparam int SYNC_CEA = 1;
    localparam int SYNC_CEB = 2;
    localparam int SYNC_DATA = 3;
    localparam int SYNC_W = 4;

    localparam logic [SYNC_W-1:0] SYNC_RST = 4'h0;
    localparam logic [2:0] CNT_RST = 3'h0;
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 4'h0;

    typedef enum logic [2:0] {
        st_mode,
        st_addr,
        st_write,
        st_read,
        st_ignore
    } port_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] data;
    } reg_write_s;

endpackage

// File: hdl/word_fifo.sv
`timescale 1ns/10ps
module word_fifo
#(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
)
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    // depth must be a power of two so the pointers wrap by themselves
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0] count_r;
    logic push;
    logic pop;

    assign in_ready_o = (count_r != (PW+1)'(DEPTH));
    assign out_valid_o = (count_r != '0);
    assign out_data_o = mem_r[rd_ptr_r];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    always_ff @(posedge core_clk_i)
    begin
        if (push)
        begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop)
            begin
                count_r <= count_r + 1'b1;
            end
            else if (pop && !push)
            begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule

// File: hdl/rtc_three_wire_serial_port.sv
`timescale 1ns/10ps
module rtc_three_wire_serial_port
    import rtc_serial_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic sclk_i,
    input wire logic chip_enable_a_i,
    input wire logic chip_enable_b_i,
    input wire logic data_i,
    output logic data_o,
    output logic data_oe_o,
    output logic [ADDR_W-1:0] rd_addr_o,
    input wire logic [BYTE_W-1:0] rd_data_i,
    output logic upd_valid_o,
    output reg_write_s upd_word_o,
    input wire logic upd_ready_i,
    output logic write_drop_o
);

    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic sclk_d_r;
    logic ce_s;
    logic data_s;
    logic sclk_rise;
    logic sclk_fall;

    port_state_e state_r;
    port_state_e state_nxt;
    logic [2:0] bit_cnt_r;
    logic [2:0] bit_cnt_nxt;
    logic [BYTE_W-1:0] shift_r;
    logic [BYTE_W-1:0] shift_nxt;
    logic [BYTE_W-1:0] shift_in;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] addr_nxt;
    logic rd_mode_r;
    logic rd_mode_nxt;
    logic push_req;
    logic fifo_in_ready;
    logic [$bits(reg_write_s)-1:0] fifo_out;
    logic [BYTE_W-1:0] out_sh_r;
    reg_write_s push_word;

    function automatic logic [ADDR_W-1:0] next_addr(
        input logic [ADDR_W-1:0] a
    );
        // natural 4-bit overflow gives the F to 0 wrap
        next_addr = a + 4'h1;
    endfunction

    // pins are asynchronous to the core clock; two flops each
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            sync1_r <= SYNC_RST;
            sync2_r <= SYNC_RST;
            sclk_d_r <= 1'b0;
        end
        else
        begin
            sync1_r <= {data_i, chip_enable_b_i, chip_enable_a_i, sclk_i};
            sync2_r <= sync1_r;
            sclk_d_r <= sync2_r[SYNC_SCLK];
        end
    end

    // RULE_01 combined enable
    assign ce_s = sync2_r[SYNC_CEA] & sync2_r[SYNC_CEB];
    assign data_s = sync2_r[SYNC_DATA];
    // RULE_11 serial clock edges
    assign sclk_rise = sync2_r[SYNC_SCLK] & ~sclk_d_r;
    assign sclk_fall = ~sync2_r[SYNC_SCLK] & sclk_d_r;

    // RULE_03 new bit enters at the top
    assign shift_in = {data_s, shift_r[BYTE_W-1:1]};

    always_comb
    begin
        state_nxt = state_r;
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt = shift_r;
        addr_nxt = addr_r;
        rd_mode_nxt = rd_mode_r;
        push_req = 1'b0;
        if (!ce_s)
        begin
            // RULE_07 RULE_12 drop partial byte
            state_nxt = st_mode;
            bit_cnt_nxt = CNT_RST;
            shift_nxt = BYTE_RST;
        end
        else if (sclk_rise)
        begin
            shift_nxt = shift_in;
            bit_cnt_nxt = bit_cnt_r + 3'h1;
            unique case (state_r)
                st_mode:
                begin
                    // RULE_02 mode nibble first
                    if (bit_cnt_r == MODE_LAST_BIT)
                    begin
                        // RULE_05 write code
                        if (shift_in[7:4] == MODE_WRITE)
                        begin
                            state_nxt = st_addr;
                            rd_mode_nxt = 1'b0;
                        end
                        // RULE_08 read code
                        else if (shift_in[7:4] == MODE_READ)
                        begin
                            state_nxt = st_addr;
                            rd_mode_nxt = 1'b1;
                        end
                        // RULE_10 unknown code
                        else
                        begin
                            state_nxt = st_ignore;
                        end
                    end
                end
                st_addr:
                begin
                    if (bit_cnt_r == BYTE_LAST_BIT)
                    begin
                        addr_nxt = shift_in[7:4];
                        state_nxt = rd_mode_r ? st_read : st_write;
                    end
                end
                st_write:
                begin
                    // RULE_06 commit whole byte
                    if (bit_cnt_r == BYTE_LAST_BIT)
                    begin
                        push_req = 1'b1;
                        // RULE_04 address step
                        addr_nxt = next_addr(addr_r);
                    end
                end
                st_read:
                begin
                    // RULE_04 address step
                    if (bit_cnt_r == BYTE_LAST_BIT)
                    begin
                        addr_nxt = next_addr(addr_r);
                    end
                end
                st_ignore:
                begin
                    state_nxt = st_ignore;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            state_r <= st_mode;
            bit_cnt_r <= CNT_RST;
            shift_r <= BYTE_RST;
            rd_mode_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r <= shift_nxt;
            rd_mode_r <= rd_mode_nxt;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            addr_r <= ADDR_RST;
        end
        else
        begin
            addr_r <= addr_nxt;
        end
    end

    assign rd_addr_o = addr_r;

    // RULE_09 read shifter
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            data_o <= 1'b0;
            data_oe_o <= 1'b0;
            out_sh_r <= BYTE_RST;
        end
        else if (!ce_s || state_r != st_read)
        begin
            // RULE_12 release data line
            data_oe_o <= 1'b0;
        end
        else if (sclk_fall)
        begin
            // bits change on the falling edge so the host sees them settled
            data_oe_o <= 1'b1;
            if (bit_cnt_r == CNT_RST)
            begin
                data_o <= rd_data_i[0];
                out_sh_r <= {1'b0, rd_data_i[BYTE_W-1:1]};
            end
            else
            begin
                data_o <= out_sh_r[0];
                out_sh_r <= {1'b0, out_sh_r[BYTE_W-1:1]};
            end
        end
    end

    // host cannot be stalled, so a full queue loses the byte; flag it
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            write_drop_o <= 1'b0;
        end
        else if (push_req && !fifo_in_ready)
        begin
            write_drop_o <= 1'b1;
        end
    end

    assign push_word = '{addr: addr_r, data: shift_in};

    word_fifo #(
        .WIDTH($bits(reg_write_s)),
        .DEPTH(UPD_FIFO_DEPTH)
    ) u_upd_fifo (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .in_valid_i(push_req),
        .in_ready_o(fifo_in_ready),
        .in_data_i(push_word),
        .out_valid_o(upd_valid_o),
        .out_ready_i(upd_ready_i),
        .out_data_o(fifo_out)
    );

    assign upd_word_o = reg_write_s'(fifo_out);

    a_oe_needs_ce: assert property ( // RULE_01
        @(posedge core_clk_i) disable iff (srst_i)
        data_oe_o |-> $past(ce_s)
    ) else $error("data line driven without chip enable");

    a_mode_nibble_end: assert property ( // RULE_02
        @(posedge core_clk_i) disable iff (srst_i)
        (state_r == st_mode && sclk_rise && ce_s
            && bit_cnt_r == MODE_LAST_BIT)
        |=> (state_r == st_addr || state_r == st_ignore)
    ) else $error("mode phase did not end after four bits");

    a_lsb_shift_in: assert property ( // RULE_03
        @(posedge core_clk_i) disable iff (srst_i)
        (sclk_rise && ce_s) |=> shift_r[7] == $past(data_s)
    ) else $error("received bit not shifted in at the top");

    a_addr_wraps: assert property ( // RULE_04
        @(posedge core_clk_i) disable iff (srst_i)
        (state_r == st_write && sclk_rise && ce_s
            && bit_cnt_r == BYTE_LAST_BIT && addr_r == 4'hf)
        |=> addr_r == 4'h0
    ) else $error("address did not wrap from f to 0");

    a_write_select: assert property ( // RULE_05
        @(posedge core_clk_i) disable iff (srst_i)
        (state_r == st_mode && sclk_rise && ce_s
            && bit_cnt_r == MODE_LAST_BIT
            && {data_s, shift_r[7:5]} == MODE_WRITE)
        |=> (state_r == st_addr && !rd_mode_r) [*1]
    ) else $error("write code did not select write");

    a_write_commit: assert property ( // RULE_06
        @(posedge core_clk_i) disable iff (srst_i)
        (push_req && fifo_in_ready) |=> upd_valid_o
    ) else $error("committed byte not offered to core");

    a_partial_dropped: assert property ( // RULE_07
        @(posedge core_clk_i) disable iff (srst_i)
        push_req |-> ce_s && state_r == st_write && bit_cnt_r == BYTE_LAST_BIT
    ) else $error("byte committed without chip enable");

    a_read_select: assert property ( // RULE_08
        @(posedge core_clk_i) disable iff (srst_i)
        (state_r == st_mode && sclk_rise && ce_s
            && bit_cnt_r == MODE_LAST_BIT
            && {data_s, shift_r[7:5]} == MODE_READ)
        |=> state_r == st_addr && rd_mode_r
    ) else $error("read code did not select read");

    a_read_drives: assert property ( // RULE_09
        @(posedge core_clk_i) disable iff (srst_i)
        (state_r == st_read && sclk_fall && ce_s && bit_cnt_r == 3'h0)
        |=> data_oe_o && data_o == $past(rd_data_i[0])
    ) else $error("read byte not driven at falling edge");

    a_ignore_quiet: assert property ( // RULE_10
        @(posedge core_clk_i) disable iff (srst_i)
        state_r == st_ignore |=> !data_oe_o
    ) else $error("data line driven after unknown mode");

    a_out_on_fall: assert property ( // RULE_11
        @(posedge core_clk_i) disable iff (srst_i)
        sclk_rise |=> $stable(data_o)
    ) else $error("read bit changed at rising edge");

    a_ce_release: assert property ( // RULE_12
        @(posedge core_clk_i) disable iff (srst_i)
        !ce_s |=> state_r == st_mode && bit_cnt_r == 3'h0 && !data_oe_o
    ) else $error("state not cleared after chip enable fell");

endmodule

// File: testbench/rtc_host_model.sv
`timescale 1ns/10ps
module rtc_host_model
(
    input wire logic core_clk_i,
    input wire logic dev_data_i,
    input wire logic dev_oe_i,
    output logic sclk_o,
    output logic cea_o,
    output logic ceb_o,
    output logic line_o
);
    // 20 core cycles per phase gives the 160 ns serial period
    localparam int HALF = 20;
    logic host_oe_r = 1'b0;
    logic host_val_r = 1'b0;
    logic last_r = 1'b0;

    initial
    begin
        sclk_o = 1'b0;
        cea_o = 1'b0;
        ceb_o = 1'b0;
    end

    // no pull on the line: an undriven line keeps toggling
    assign line_o = dev_oe_i ? dev_data_i : (host_oe_r ? host_val_r : ~last_r);

    always @(posedge core_clk_i)
        last_r <= line_o;

    task automatic frame_open(input logic a, input logic b);
        @(posedge core_clk_i);
        cea_o <= a;
        ceb_o <= b;
        repeat (HALF) @(posedge core_clk_i);
    endtask

    task automatic frame_close();
        @(posedge core_clk_i);
        sclk_o <= 1'b0;
        repeat (HALF) @(posedge core_clk_i);
        cea_o <= 1'b0;
        ceb_o <= 1'b0;
        host_oe_r <= 1'b0;
        repeat (HALF) @(posedge core_clk_i);
    endtask

    task automatic shift_bit(input logic b, input logic drv, output logic r);
        @(posedge core_clk_i);
        sclk_o <= 1'b0;
        host_oe_r <= drv;
        host_val_r <= b;
        repeat (HALF) @(posedge core_clk_i);
        r = line_o;
        sclk_o <= 1'b1;
        repeat (HALF - 1) @(posedge core_clk_i);
    endtask

    task automatic shift_byte(input logic [7:0] w, input logic drv,
                              output logic [7:0] r);
        for (int i = 0; i < 8; i++)
            shift_bit(w[i], drv, r[i]);
    endtask
endmodule

// File: testbench/rtc_three_wire_serial_port_bench.sv
`timescale 1ns/10ps
module rtc_three_wire_serial_port_bench
    import rtc_serial_pkg::*;
;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic sclk, cea, ceb, line, dev_data, dev_oe, oe_seen;
    logic upd_valid, write_drop;
    logic upd_ready = 1'b0;
    logic [ADDR_W-1:0] rd_addr;
    logic [BYTE_W-1:0] rd_data;
    logic [BYTE_W-1:0] regs [16];
    reg_write_s upd_word;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;

    rtc_three_wire_serial_port dut (.core_clk_i(core_clk), .srst_i(srst),
        .sclk_i(sclk), .chip_enable_a_i(cea), .chip_enable_b_i(ceb),
        .data_i(line), .data_o(dev_data), .data_oe_o(dev_oe),
        .rd_addr_o(rd_addr), .rd_data_i(rd_data), .upd_valid_o(upd_valid),
        .upd_word_o(upd_word), .upd_ready_i(upd_ready),
        .write_drop_o(write_drop));

    rtc_host_model host (.core_clk_i(core_clk), .dev_data_i(dev_data),
        .dev_oe_i(dev_oe), .sclk_o(sclk), .cea_o(cea), .ceb_o(ceb),
        .line_o(line));

    // the core answers reads from its register copy
    assign rd_data = regs[rd_addr];

    initial
        forever #2 core_clk = ~core_clk;

    always @(posedge core_clk)
        if (dev_oe === 1'b1)
            oe_seen <= 1'b1;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic pop_word(input logic [11:0] exp);
        int n;
        n = 0;
        while (upd_valid !== 1'b1 && n < 50)
        begin
            @(posedge core_clk);
            n++;
        end
        check(upd_valid, 1'b1);
        check(upd_word, exp);
        upd_ready <= 1'b1;
        @(posedge core_clk);
        upd_ready <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic test_reset();
        check({dev_oe, upd_valid, write_drop}, 3'h0);
        check(rd_addr, 4'h0);
    endtask

    // far side stalls while 17 bytes arrive; the last finds the buffer full
    task automatic test_write_fill();
        logic [7:0] r;
        host.frame_open(1'b1, 1'b1);
        host.shift_byte({4'he, MODE_WRITE}, 1'b1, r);
        for (int i = 0; i < 17; i++)
            host.shift_byte(8'h30 + i[7:0], 1'b1, r);
        host.frame_close();
        check(write_drop, 1'b1);
        for (int i = 0; i < 16; i++)
            pop_word({4'he + i[3:0], 8'h30 + i[7:0]});
        check(upd_valid, 1'b0);
    endtask

    task automatic test_read();
        logic [7:0] r;
        host.frame_open(1'b1, 1'b1);
        host.shift_byte({4'hf, MODE_READ}, 1'b1, r);
        host.shift_byte(8'h00, 1'b0, r);
        check(r, regs[15]);
        host.shift_byte(8'h00, 1'b0, r);
        check(r, regs[0]);
        host.frame_close();
        check(dev_oe, 1'b0);
    endtask

    task automatic test_ignore();
        logic [7:0] r;
        for (int m = 0; m < 16; m++)
        begin
            if (m[3:0] == MODE_WRITE || m[3:0] == MODE_READ)
                continue;
            oe_seen = 1'b0;
            host.frame_open(1'b1, 1'b1);
            host.shift_byte({4'h2, m[3:0]}, 1'b1, r);
            host.shift_byte(8'h00, 1'b0, r);
            host.shift_byte(8'h3c, 1'b1, r);
            host.frame_close();
            check({oe_seen, upd_valid}, 2'h0);
        end
    endtask

    task automatic test_partial();
        logic [7:0] r;
        logic b;
        host.frame_open(1'b1, 1'b0);
        host.shift_byte({4'h1, MODE_WRITE}, 1'b1, r);
        host.shift_byte(8'h77, 1'b1, r);
        host.frame_close();
        check(upd_valid, 1'b0);
        host.frame_open(1'b1, 1'b1);
        host.shift_byte({4'h1, MODE_WRITE}, 1'b1, r);
        for (int i = 0; i < 5; i++)
            host.shift_bit(1'b1, 1'b1, b);
        host.frame_close();
        check(upd_valid, 1'b0);
        host.frame_open(1'b1, 1'b1);
        host.shift_byte({4'h1, MODE_WRITE}, 1'b1, r);
        host.shift_byte(8'h96, 1'b1, r);
        host.frame_close();
        pop_word({4'h1, 8'h96});
    endtask

    // ceiling well above the roughly 23000 cycles the tests need
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            fails = fails + 1;
            finish_test();
        end
    end

    initial
    begin
        for (int i = 0; i < 16; i++)
            regs[i] = {i[3:0], ~i[3:0]};
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        repeat (4) @(posedge core_clk);
        test_reset();
        test_write_fill();
        test_read();
        test_ignore();
        test_partial();
        finish_test();
    end
endmodule
